// [hdl/pbl_protection_blocking_logic.sv]
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module pbl_protection_blocking_logic (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pbl_pkg::NUM_SIG-1:0] digitalIn,
  input wire logic [pbl_pkg::NUM_SIG-1:0] internalSig,
  input wire logic [pbl_pkg::NUM_MOD-1:0] reverseInterlock,
  input wire logic [pbl_pkg::NUM_MOD-1:0] stagePickup,
  input wire logic [pbl_pkg::NUM_MOD-1:0] stageTrip,
  output logic [pbl_pkg::NUM_MOD-1:0] stageActive,
  output logic [pbl_pkg::NUM_MOD-1:0] alarmOut,
  output logic [pbl_pkg::NUM_MOD-1:0] tripCmd,
  output logic protActive
);

  ////////////////////////////////////////////////////////////////////////////////
  // Assignable signal list: digital inputs then internal signals
  function automatic logic pick(input logic [2*pbl_pkg::NUM_SIG-1:0] list,
                                input logic [pbl_pkg::SEL_W-1:0] sel);
    if (sel == pbl_pkg::SEL_NONE) begin
      pick = 1'b0;
    end else begin
      pick = list[sel];
    end
  endfunction

  // Byte enable merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  // Aligned word address inside the register map, shared by write and read decode
  function automatic logic inMap(input logic [7:0] addr);
    inMap = addr[1:0] == 2'h0 && addr <= pbl_pkg::OFF_TRIP_STAT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [pbl_pkg::NUM_SIG-1:0] digMeta_q, digSync_q;
  logic [pbl_pkg::NUM_MOD-1:0] revMeta_q, revSync_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      digMeta_q <= '0;
      digSync_q <= '0;
      revMeta_q <= '0;
      revSync_q <= '0;
    end else begin
      digMeta_q <= digitalIn;
      digSync_q <= digMeta_q;
      revMeta_q <= reverseInterlock;
      revSync_q <= revMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] global_q, modEn_q, exbPermit_q, tripInh_q, tripPermit_q, revPermit_q, sel_q;
  logic awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrHit;

  assign wrAddr = s_axi_awready && s_axi_awvalid ? s_axi_awaddr : awAddr_q;
  assign wrData = s_axi_wready && s_axi_wvalid ? s_axi_wdata : wData_q;
  assign wrStrb = s_axi_wready && s_axi_wvalid ? s_axi_wstrb : wStrb_q;
  assign doWrite = (awHeld_q || (s_axi_awready && s_axi_awvalid)) &&
                   (wHeld_q || (s_axi_wready && s_axi_wvalid)) && !s_axi_bvalid;
  assign wrHit = inMap(wrAddr);

  // Write channel capture, either order
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pbl_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !(s_axi_awready && s_axi_awvalid) && !s_axi_bvalid;
      s_axi_wready <= !wHeld_q && !(s_axi_wready && s_axi_wvalid) && !s_axi_bvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? pbl_pkg::RESP_OKAY : pbl_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awready && s_axi_awvalid) begin
          awHeld_q <= 1'b1;
        end
        if (s_axi_wready && s_axi_wvalid) begin
          wHeld_q <= 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Setting registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      global_q <= pbl_pkg::RST_GLOBAL;
      modEn_q <= pbl_pkg::RST_ZERO;
      exbPermit_q <= pbl_pkg::RST_ZERO;
      tripInh_q <= pbl_pkg::RST_ZERO;
      tripPermit_q <= pbl_pkg::RST_ZERO;
      revPermit_q <= pbl_pkg::RST_ZERO;
      sel_q <= pbl_pkg::RST_SEL;
    end else if (doWrite) begin
      case (wrAddr)
        pbl_pkg::OFF_GLOBAL: global_q <= merge(global_q, wrData, wrStrb);
        pbl_pkg::OFF_MOD_EN: modEn_q <= merge(modEn_q, wrData, wrStrb);
        pbl_pkg::OFF_EXB_PERMIT: exbPermit_q <= merge(exbPermit_q, wrData, wrStrb);
        pbl_pkg::OFF_TRIP_INH: tripInh_q <= merge(tripInh_q, wrData, wrStrb);
        pbl_pkg::OFF_TRIP_PERMIT: tripPermit_q <= merge(tripPermit_q, wrData, wrStrb);
        pbl_pkg::OFF_REV_PERMIT: revPermit_q <= merge(revPermit_q, wrData, wrStrb);
        pbl_pkg::OFF_SEL: sel_q <= merge(sel_q, wrData, wrStrb);
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Blocking logic
  logic [2*pbl_pkg::NUM_SIG-1:0] sigList;
  logic glbBlock, blkOne, blkTwo, tripBlkSrc, globalOk;
  logic [pbl_pkg::NUM_MOD-1:0] modOk, tripOk;

  assign sigList = {internalSig, digSync_q};
  assign blkOne = pick(sigList, sel_q[pbl_pkg::SEL_B1_POS +: pbl_pkg::SEL_W]);
  assign blkTwo = pick(sigList, sel_q[pbl_pkg::SEL_B2_POS +: pbl_pkg::SEL_W]);
  assign tripBlkSrc = pick(sigList, sel_q[pbl_pkg::SEL_TB_POS +: pbl_pkg::SEL_W]);
  // Global block: permit and assigned signal
  assign glbBlock = global_q[pbl_pkg::GLB_PERMIT_BIT] &&
                    pick(sigList, sel_q[pbl_pkg::SEL_GLB_POS +: pbl_pkg::SEL_W]);
  assign globalOk = global_q[pbl_pkg::GLB_EN_BIT] && !glbBlock;

  // Per-module gating
  genvar g;
  generate
    for (g = 0; g < pbl_pkg::NUM_MOD; g++) begin : gMod
      assign modOk[g] = globalOk && modEn_q[g] &&
                        !(exbPermit_q[g] && (blkOne || blkTwo)) &&
                        !(revPermit_q[g] && revSync_q[g]);
      assign tripOk[g] = modOk[g] && !tripInh_q[g] &&
                         !(tripPermit_q[g] && tripBlkSrc);
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stageActive <= '0;
      alarmOut <= '0;
      tripCmd <= '0;
      protActive <= 1'b0;
    end else begin
      protActive <= globalOk;
      stageActive <= modOk;
      alarmOut <= modOk & stagePickup;
      tripCmd <= tripOk & stageTrip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rdMux;
  always_comb begin
    rdMux = '0;
    case (s_axi_araddr)
      pbl_pkg::OFF_GLOBAL: rdMux = global_q;
      pbl_pkg::OFF_MOD_EN: rdMux = modEn_q;
      pbl_pkg::OFF_EXB_PERMIT: rdMux = exbPermit_q;
      pbl_pkg::OFF_TRIP_INH: rdMux = tripInh_q;
      pbl_pkg::OFF_TRIP_PERMIT: rdMux = tripPermit_q;
      pbl_pkg::OFF_REV_PERMIT: rdMux = revPermit_q;
      pbl_pkg::OFF_SEL: rdMux = sel_q;
      pbl_pkg::OFF_STATUS: rdMux = {16'h0000, stageActive, 7'h00, protActive};
      pbl_pkg::OFF_TRIP_STAT: rdMux = {16'h0000, alarmOut, tripCmd};
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pbl_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arready && s_axi_arvalid);
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= inMap(s_axi_araddr) ? pbl_pkg::RESP_OKAY : pbl_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_global_off;
    @(posedge clk) disable iff (!rst_b)
      !global_q[pbl_pkg::GLB_EN_BIT] |=> (tripCmd == '0 && alarmOut == '0 && !protActive);
  endproperty
  a_global_off: assert property (p_global_off) else $error("output while global off");

  property p_mod_off;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> ((stageActive & ~$past(modEn_q[pbl_pkg::NUM_MOD-1:0])) == '0);
  endproperty
  a_mod_off: assert property (p_mod_off) else $error("disabled module active");

  property p_inhibit;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> ((tripCmd & $past(tripInh_q[pbl_pkg::NUM_MOD-1:0])) == '0);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("trip despite inhibit");

  property p_glb_block;
    @(posedge clk) disable iff (!rst_b)
      glbBlock |=> !protActive && stageActive == '0;
  endproperty
  a_glb_block: assert property (p_glb_block) else $error("global block ignored");

  property p_no_permit;
    @(posedge clk) disable iff (!rst_b)
      (globalOk && modEn_q[0] && !exbPermit_q[0] && !(revPermit_q[0] && revSync_q[0]))
        |=> stageActive[0];
  endproperty
  a_no_permit: assert property (p_no_permit) else $error("unpermitted block");

  property p_either_block;
    @(posedge clk) disable iff (!rst_b)
      (exbPermit_q[0] && (blkOne || blkTwo)) |=> !stageActive[0];
  endproperty
  a_either_block: assert property (p_either_block) else $error("block input ignored");

  property p_trip_block;
    @(posedge clk) disable iff (!rst_b)
      (tripPermit_q[0] && tripBlkSrc) |=> !tripCmd[0];
  endproperty
  a_trip_block: assert property (p_trip_block) else $error("trip block ignored");

  property p_rev;
    @(posedge clk) disable iff (!rst_b)
      (revPermit_q[0] && revSync_q[0]) |=> !stageActive[0];
  endproperty
  a_rev: assert property (p_rev) else $error("reverse interlock ignored");

  property p_trip_ok;
    @(posedge clk) disable iff (!rst_b)
      (tripOk[0] && stageTrip[0]) |=> tripCmd[0] && stageActive[0];
  endproperty
  a_trip_ok: assert property (p_trip_ok) else $error("trip not issued");

  // Every pin bit reaches its synchroniser output exactly two edges late, once reset is two edges old
  property p_sync_delay;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && $past(rst_b, 2) |-> digSync_q == $past(digitalIn, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("input sync lag wrong");

  property p_rev_sync;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && $past(rst_b, 2) |-> revSync_q == $past(reverseInterlock, 2);
  endproperty
  a_rev_sync: assert property (p_rev_sync) else $error("interlock sync lag wrong");

  property p_alarm_gate;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> ((alarmOut & ~(stageActive & $past(stagePickup))) == '0);
  endproperty
  a_alarm_gate: assert property (p_alarm_gate) else $error("alarm from idle stage");

  property p_trip_gate;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> ((tripCmd & ~(stageActive & $past(stageTrip))) == '0);
  endproperty
  a_trip_gate: assert property (p_trip_gate) else $error("trip without stage trip");

  // Bus handshakes: one write and one read at a time, answers drop once accepted
  property p_one_write;
    @(posedge clk) disable iff (!rst_b)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_one_write: assert property (p_one_write) else $error("write taken during response");

  property p_write_done;
    @(posedge clk) disable iff (!rst_b)
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write response not retired");

  property p_one_read;
    @(posedge clk) disable iff (!rst_b)
      s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_one_read: assert property (p_one_read) else $error("read taken during response");

  property p_read_done;
    @(posedge clk) disable iff (!rst_b)
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read response not retired");

endmodule

// [hdl/pbl_pkg.sv]
// Behaviour
// - One global enable switches all protection of the device on or off at once.
// - With the global enable off no module operates and no trip or alarm leaves any module.
// - Each module has its own enable; when it is off the module is switched off alone.
// - Each stage has a permanent trip inhibit that always suppresses its breaker trip.
// - The global protection is blocked while its assigned block signal is on, if permitted.
// - A module can be blocked temporarily by the block inputs only when its external block permit is set.
// - Two assignable block inputs exist; a permitted module is blocked while either is on.
// - A stage trip is blocked while its trip block source is on, if its trip block permit is set.
// - Any signal of the assignable signal list but the top one (code 5'h1F means none) may be selected as a block source.
// - Phase and ground current modules can also be blocked by reverse interlocking.
package pbl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_MOD = 8;
  localparam int NUM_SIG = 16;
  localparam int SEL_W = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_GLOBAL = 8'h00;
  localparam logic [7:0] OFF_MOD_EN = 8'h04;
  localparam logic [7:0] OFF_EXB_PERMIT = 8'h08;
  localparam logic [7:0] OFF_TRIP_INH = 8'h0C;
  localparam logic [7:0] OFF_TRIP_PERMIT = 8'h10;
  localparam logic [7:0] OFF_REV_PERMIT = 8'h14;
  localparam logic [7:0] OFF_SEL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_TRIP_STAT = 8'h20;

  ////////////////////////////////////////////////////////////////////////////////
  // Global register fields
  localparam int GLB_EN_BIT = 0;
  localparam int GLB_PERMIT_BIT = 1;
  // Selector fields in OFF_SEL: global, block one, block two, trip block source
  localparam int SEL_GLB_POS = 0;
  localparam int SEL_B1_POS = 8;
  localparam int SEL_B2_POS = 16;
  localparam int SEL_TB_POS = 24;
  // Selector value meaning nothing assigned
  localparam logic [SEL_W-1:0] SEL_NONE = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_GLOBAL = 32'h00000000;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [31:0] RST_SEL = 32'h1F1F1F1F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [testbench/pbl_protection_blocking_logic_bench.sv]
`timescale 1ns/1ps
module pbl_protection_blocking_logic_bench;
  logic clk, rst_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] digitalIn, internalSig;
  logic [7:0] reverseInterlock, stagePickup, stageTrip, stageActive, alarmOut, tripCmd;
  logic protActive;
  int n_mismatch;
  int comparisons;

  pbl_protection_blocking_logic pbl_protection_blocking_logic_inst (
    .clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .digitalIn(digitalIn),
    .internalSig(internalSig), .reverseInterlock(reverseInterlock),
    .stagePickup(stagePickup), .stageTrip(stageTrip), .stageActive(stageActive),
    .alarmOut(alarmOut), .tripCmd(tripCmd), .protActive(protActive)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One AXI write, waits for the response and compares its code
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // One AXI read, compares data and response code
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // Lets pin synchronisers and output registers settle, then compares all outputs
  task automatic outs(input logic p, input logic [7:0] sa, input logic [7:0] al,
                      input logic [7:0] tc);
    repeat (6) @(posedge clk);
    chk({31'h0, protActive}, {31'h0, p});
    chk({24'h0, stageActive}, {24'h0, sa});
    chk({24'h0, alarmOut}, {24'h0, al});
    chk({24'h0, tripCmd}, {24'h0, tc});
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    outs(1'b0, 8'h00, 8'h00, 8'h00);
    rd(pbl_pkg::OFF_GLOBAL, pbl_pkg::RST_GLOBAL, pbl_pkg::RESP_OKAY);
    rd(pbl_pkg::OFF_SEL, pbl_pkg::RST_SEL, pbl_pkg::RESP_OKAY);
    rd(8'h40, 32'h00000000, pbl_pkg::RESP_SLVERR);
    wr(8'h40, 32'hFFFFFFFF, pbl_pkg::RESP_SLVERR);
    wr(pbl_pkg::OFF_STATUS, 32'hFFFFFFFF, pbl_pkg::RESP_OKAY);
    rd(pbl_pkg::OFF_STATUS, 32'h00000000, pbl_pkg::RESP_OKAY);
    // Byte lanes: only lane one of the selector word changes
    s_axi_wstrb <= 4'h2;
    wr(pbl_pkg::OFF_SEL, 32'h00000500, pbl_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(pbl_pkg::OFF_SEL, 32'h1F1F051F, pbl_pkg::RESP_OKAY);
    $display("test reset done");
  endtask

  task automatic t_global();
    wr(pbl_pkg::OFF_MOD_EN, 32'h000000FF, pbl_pkg::RESP_OKAY);
    stagePickup <= 8'hFF;
    stageTrip <= 8'hFF;
    outs(1'b0, 8'h00, 8'h00, 8'h00);
    wr(pbl_pkg::OFF_GLOBAL, 32'h00000001, pbl_pkg::RESP_OKAY);
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    rd(pbl_pkg::OFF_STATUS, 32'h0000FF01, pbl_pkg::RESP_OKAY);
    stageTrip <= 8'h00;
    outs(1'b1, 8'hFF, 8'hFF, 8'h00);
    stageTrip <= 8'hFF;
    $display("test global done");
  endtask

  task automatic t_module();
    wr(pbl_pkg::OFF_MOD_EN, 32'h0000000F, pbl_pkg::RESP_OKAY);
    stagePickup <= 8'h3C;
    outs(1'b1, 8'h0F, 8'h0C, 8'h0F);
    stagePickup <= 8'hFF;
    wr(pbl_pkg::OFF_MOD_EN, 32'h000000FF, pbl_pkg::RESP_OKAY);
    wr(pbl_pkg::OFF_TRIP_INH, 32'h00000005, pbl_pkg::RESP_OKAY);
    outs(1'b1, 8'hFF, 8'hFF, 8'hFA);
    rd(pbl_pkg::OFF_TRIP_STAT, 32'h0000FFFA, pbl_pkg::RESP_OKAY);
    wr(pbl_pkg::OFF_TRIP_INH, 32'h00000000, pbl_pkg::RESP_OKAY);
    $display("test module and inhibit done");
  endtask

  task automatic t_gblock();
    wr(pbl_pkg::OFF_SEL, 32'h1F1F1F03, pbl_pkg::RESP_OKAY);
    digitalIn <= 16'h0008;
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    wr(pbl_pkg::OFF_GLOBAL, 32'h00000003, pbl_pkg::RESP_OKAY);
    outs(1'b0, 8'h00, 8'h00, 8'h00);
    digitalIn <= 16'h0000;
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    // Permit set but nothing assigned: the top list entry must not block
    wr(pbl_pkg::OFF_SEL, 32'h1F1F1F1F, pbl_pkg::RESP_OKAY);
    internalSig <= 16'h8000;
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    internalSig <= 16'h0000;
    wr(pbl_pkg::OFF_GLOBAL, 32'h00000001, pbl_pkg::RESP_OKAY);
    $display("test global block done");
  endtask

  task automatic t_modblock();
    wr(pbl_pkg::OFF_SEL, 32'h1F02111F, pbl_pkg::RESP_OKAY);
    internalSig <= 16'h0002;
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    wr(pbl_pkg::OFF_EXB_PERMIT, 32'h0000000F, pbl_pkg::RESP_OKAY);
    outs(1'b1, 8'hF0, 8'hF0, 8'hF0);
    internalSig <= 16'h0000;
    digitalIn <= 16'h0004;
    outs(1'b1, 8'hF0, 8'hF0, 8'hF0);
    digitalIn <= 16'h0000;
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    wr(pbl_pkg::OFF_EXB_PERMIT, 32'h00000000, pbl_pkg::RESP_OKAY);
    $display("test module block done");
  endtask

  task automatic t_tripblock();
    wr(pbl_pkg::OFF_SEL, 32'h141F1F1F, pbl_pkg::RESP_OKAY);
    wr(pbl_pkg::OFF_TRIP_PERMIT, 32'h0000003C, pbl_pkg::RESP_OKAY);
    internalSig <= 16'h0010;
    outs(1'b1, 8'hFF, 8'hFF, 8'hC3);
    internalSig <= 16'h0000;
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    $display("test trip block done");
  endtask

  task automatic t_reverse();
    wr(pbl_pkg::OFF_REV_PERMIT, 32'h00000081, pbl_pkg::RESP_OKAY);
    reverseInterlock <= 8'hFF;
    outs(1'b1, 8'h7E, 8'h7E, 8'h7E);
    reverseInterlock <= 8'h00;
    outs(1'b1, 8'hFF, 8'hFF, 8'hFF);
    $display("test reverse interlock done");
  endtask

  // Reset in mid-run with all stages tripping: settings and outputs return to off
  task automatic t_rerun();
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    outs(1'b0, 8'h00, 8'h00, 8'h00);
    rd(pbl_pkg::OFF_GLOBAL, pbl_pkg::RST_GLOBAL, pbl_pkg::RESP_OKAY);
    rd(pbl_pkg::OFF_REV_PERMIT, pbl_pkg::RST_ZERO, pbl_pkg::RESP_OKAY);
    $display("test reset in run done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {digitalIn, internalSig, reverseInterlock, stagePickup, stageTrip} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_global();
    t_module();
    t_gblock();
    t_modblock();
    t_tripblock();
    t_reverse();
    t_rerun();
    results();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule
